// ---- core/mcis_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcis_core
	import mcis_pkg::*;
	(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	input wire logic [WORD_W-1:0] I_INSTR,
	input wire logic [PC_W-1:0] I_STACK_TOP,
	output logic [PC_W-1:0] O_PC,
	output logic [DATA_W-1:0] O_W,
	output logic O_STATUS_Z,
	output logic [DATA_W-1:0] O_OPTION,
	output logic [3:0] O_PHASE,
	output logic O_STACK_POP,
	output logic O_FILE_WE,
	output logic [FADDR_W-1:0] O_FILE_ADDR,
	output logic [DATA_W-1:0] O_FILE_DATA,
	output logic O_SECOND_CYCLE,
	output logic O_UNSUPPORTED
	);

	// Phase enables, one clock wide each
	logic [3:0] phase;
	logic phase_one;
	logic phase_two;
	logic phase_three;
	logic phase_four;

	// Instruction and sequencing state
	logic [WORD_W-1:0] ir_reg;
	logic [WORD_W-1:0] ir_next;
	logic [PC_W-1:0] pc_reg;
	logic [PC_W-1:0] pc_next;
	mcis_cyc_t cyc_reg;
	mcis_cyc_t cyc_next;

	// Decode results
	logic hit_inc_file;
	logic hit_move_file;
	logic hit_or_lit;
	logic hit_load_lit;
	logic hit_retlw;
	logic hit_store_w;
	logic hit_nop;
	logic hit_option;
	logic hit_return;
	mcis_op_t dec_op;
	mcis_dec_t dec_next;
	mcis_dec_t dec_reg;
	logic unsup_reg;

	// Datapath
	logic [DATA_W-1:0] ram_q;
	logic [DATA_W-1:0] inc_val;
	logic [DATA_W-1:0] alu_res;
	logic [DATA_W-1:0] res_reg;
	logic file_src;
	logic two_cycle;
	logic wr_w;
	logic wr_z;
	logic wr_file;
	logic wr_opt;
	mcis_wr_t wr_reg;
	mcis_wr_t wr_next;
	logic pop_reg;
	logic [DATA_W-1:0] w_reg;
	logic [DATA_W-1:0] w_next;
	logic z_reg;
	logic z_next;
	logic [DATA_W-1:0] opt_reg;
	logic [DATA_W-1:0] opt_next;

	mcis_phase_gen #(
		.PHASES(PHASE_COUNT)
	) u_phase (
		.i_clk(I_SYS_CLK),
		.i_resetn(I_RESETN),
		.o_phase(phase)
	);

	assign phase_one = phase[PH_ONE_IDX];
	assign phase_two = phase[PH_TWO_IDX];
	assign phase_three = phase[PH_THREE_IDX];
	assign phase_four = phase[PH_FOUR_IDX];

	// Opcode matchers on the latched word
	// increment pattern
	assign hit_inc_file = (ir_reg[13:8] == OPC_INC_FILE);
	assign hit_move_file = (ir_reg[13:8] == OPC_MOVE_FILE);
	assign hit_or_lit = (ir_reg[13:8] == OPC_OR_LIT);
	assign hit_load_lit = (ir_reg[13:10] == OPC_LOAD_LIT);
	assign hit_retlw = (ir_reg[13:10] == OPC_RETLW);
	assign hit_store_w = (ir_reg[13:7] == OPC_STORE_W);
	assign hit_nop = ((ir_reg & NOP_MASK) == WORD_NOP);
	assign hit_option = (ir_reg == WORD_OPTION);
	assign hit_return = (ir_reg == WORD_RETURN);

	// Patterns are disjoint, so the chain order only matters for OP_NONE
	assign dec_op = hit_return ? OP_RETURN :
		hit_option ? OP_OPTION :
		hit_nop ? OP_NOP :
		hit_store_w ? OP_STORE_W :
		hit_inc_file ? OP_INC_FILE :
		hit_move_file ? OP_MOVE_FILE :
		hit_or_lit ? OP_OR_LIT :
		hit_load_lit ? OP_LOAD_LIT :
		hit_retlw ? OP_RETLW :
		OP_NONE;

	assign dec_next = '{op: dec_op,
		dest: ir_reg[DEST_BIT],
		addr: ir_reg[FADDR_W-1:0],
		lit: ir_reg[DATA_W-1:0]};

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			dec_reg <= DEC_RESET;
			unsup_reg <= 1'b0;
		end
		else if (phase_one)
		begin
			dec_reg <= dec_next;
			unsup_reg <= (dec_op == OP_NONE);
		end
	end

	mcis_file_ram #(
		.DEPTH(FILE_DEPTH),
		.AW(FADDR_W),
		.DW(DATA_W)
	) u_file (
		.i_clk(I_SYS_CLK),
		.i_resetn(I_RESETN),
		.i_wr_en(wr_reg.en),
		.i_wr_addr(wr_reg.addr),
		.i_wr_data(wr_reg.data),
		.i_rd_en(phase_two),
		.i_rd_addr(dec_reg.addr),
		.o_rd_data(ram_q)
	);

	// Operation classes steering the phase-four writes
	assign file_src = (dec_reg.op == OP_INC_FILE) ||
		(dec_reg.op == OP_MOVE_FILE);
	assign two_cycle = (dec_reg.op == OP_RETLW) || (dec_reg.op == OP_RETURN);
	assign wr_file = (file_src && dec_reg.dest) ||
		(dec_reg.op == OP_STORE_W);
	assign wr_w = (file_src && !dec_reg.dest) ||
		(dec_reg.op == OP_OR_LIT) ||
		(dec_reg.op == OP_LOAD_LIT) ||
		(dec_reg.op == OP_RETLW);
	// zero flag users; others keep Z
	assign wr_z = file_src || (dec_reg.op == OP_OR_LIT);
	assign wr_opt = (dec_reg.op == OP_OPTION);

	assign inc_val = ram_q + DATA_ONE;

	// Result selection; NOP and return leave W value unused
	// literal OR into W
	assign alu_res = (dec_reg.op == OP_INC_FILE) ? inc_val :
		(dec_reg.op == OP_MOVE_FILE) ? ram_q :
		(dec_reg.op == OP_OR_LIT) ? (w_reg | dec_reg.lit) :
		(dec_reg.op == OP_LOAD_LIT) ? dec_reg.lit :
		(dec_reg.op == OP_RETLW) ? dec_reg.lit :
		w_reg;

	assign wr_next = phase_three ?
		mcis_wr_t'{en: wr_file, addr: dec_reg.addr, data: alu_res} :
		mcis_wr_t'{en: 1'b0, addr: wr_reg.addr, data: wr_reg.data};

	// process in phase three, write strobe held in phase four
	always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			res_reg <= W_RESET;
			wr_reg <= WR_RESET;
			pop_reg <= 1'b0;
		end
		else
		begin
			wr_reg <= wr_next;
			pop_reg <= phase_three && two_cycle;
			if (phase_three)
				res_reg <= alu_res;
		end
	end

	assign w_next = (phase_four && wr_w) ? res_reg : w_reg;
	assign z_next = (phase_four && wr_z) ? (res_reg == DATA_ZERO) : z_reg;
	assign opt_next = (phase_four && wr_opt) ? w_reg : opt_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			w_reg <= W_RESET;
			z_reg <= Z_RESET;
			opt_reg <= OPTION_RESET;
		end
		else
		begin
			w_reg <= w_next;
			z_reg <= z_next;
			opt_reg <= opt_next;
		end
	end

	// Fetch at the phase-four edge; a pop swaps in the stack top and a
	// no-operation so the word fetched from the old PC is discarded
	// PC from stack top
	assign pc_next = !phase_four ? pc_reg :
		pop_reg ? I_STACK_TOP :
		pc_reg + PC_STEP;
	assign ir_next = !phase_four ? ir_reg :
		pop_reg ? WORD_NOP :
		I_INSTR;
	assign cyc_next = !phase_four ? cyc_reg :
		pop_reg ? CYC_FLUSH :
		CYC_EXEC;

	always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			pc_reg <= PC_RESET;
			ir_reg <= WORD_NOP;
			cyc_reg <= CYC_EXEC;
		end
		else
		begin
			pc_reg <= pc_next;
			ir_reg <= ir_next;
			cyc_reg <= cyc_next;
		end
	end

	// Outputs taken from flip-flops, except O_SECOND_CYCLE which is decoded from cyc_reg
	assign O_PC = pc_reg;
	assign O_W = w_reg;
	assign O_STATUS_Z = z_reg;
	assign O_OPTION = opt_reg;
	assign O_PHASE = phase;
	assign O_STACK_POP = pop_reg;
	assign O_FILE_WE = wr_reg.en;
	assign O_FILE_ADDR = wr_reg.addr;
	assign O_FILE_DATA = wr_reg.data;
	assign O_SECOND_CYCLE = (cyc_reg == CYC_FLUSH);
	assign O_UNSUPPORTED = unsup_reg;

endmodule
`default_nettype wire

// ---- core/mcis_pkg.sv ----
// Operation
// - Increment file register, set Z, result to W or file by d.
// - OR eight-bit literal into W in one cycle, set Z.
// - Move file register to W or back to itself, set Z.
// - Load literal into W, ignore don't-care bits, flags untouched.
// - Store W into addressed file register in one cycle, flags untouched.
// - Decode 00 0000 0xx0 0000 as one-cycle no-operation.
// - Legacy option load copies W into option register, flags untouched.
// - Return-with-literal loads W with the literal and PC from stack top, two cycles.
// - Return-with-literal writes W and pops in phase four, then idles.
// - Subroutine return pops in phase four, loads PC, idles one cycle.
// - File ops decode, read, process, write in phases one to four.
package mcis_pkg;

	localparam int PHASE_COUNT = 4;
	localparam int PC_W = 13;
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	// Phase positions inside the one-hot phase vector
	localparam int PH_ONE_IDX = 0;
	localparam int PH_TWO_IDX = 1;
	localparam int PH_THREE_IDX = 2;
	localparam int PH_FOUR_IDX = 3;
	localparam logic [3:0] PHASE_RESET = 4'h1;

	// Field positions in the instruction word
	localparam int DEST_BIT = 7;

	// Values after reset, program counter step and data constants
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_STEP = 13'h0001;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [7:0] OPTION_RESET = 8'hFF;
	localparam logic [7:0] DATA_ZERO = 8'h00;
	localparam logic [7:0] DATA_ONE = 8'h01;
	localparam logic Z_RESET = 1'b0;

	// Opcode patterns
	localparam logic [5:0] OPC_INC_FILE = 6'h0A;
	localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
	localparam logic [5:0] OPC_OR_LIT = 6'h38;
	localparam logic [3:0] OPC_LOAD_LIT = 4'hC;
	localparam logic [3:0] OPC_RETLW = 4'hD;
	localparam logic [6:0] OPC_STORE_W = 7'h01;
	localparam logic [13:0] NOP_MASK = 14'h3F9F;
	localparam logic [13:0] WORD_NOP = 14'h0000;
	localparam logic [13:0] WORD_OPTION = 14'h0062;
	localparam logic [13:0] WORD_RETURN = 14'h0008;

	typedef enum logic [9:0] {
		OP_NOP = 10'h001,
		OP_INC_FILE = 10'h002,
		OP_MOVE_FILE = 10'h004,
		OP_OR_LIT = 10'h008,
		OP_LOAD_LIT = 10'h010,
		OP_RETLW = 10'h020,
		OP_STORE_W = 10'h040,
		OP_OPTION = 10'h080,
		OP_RETURN = 10'h100,
		OP_NONE = 10'h200
	} mcis_op_t;

	typedef enum logic [1:0] {
		CYC_EXEC = 2'h1,
		CYC_FLUSH = 2'h2
	} mcis_cyc_t;

	typedef struct packed {
		mcis_op_t op;
		logic dest;
		logic [6:0] addr;
		logic [7:0] lit;
	} mcis_dec_t;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} mcis_wr_t;

	localparam mcis_dec_t DEC_RESET = '{op: OP_NOP, dest: 1'b0,
		addr: 7'h00, lit: 8'h00};
	localparam mcis_wr_t WR_RESET = '{en: 1'b0, addr: 7'h00, data: 8'h00};

endpackage

// ---- core/mcis_phase_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcis_phase_gen
	import mcis_pkg::*;
	#(
	parameter int PHASES = PHASE_COUNT
	)
	(
	input wire logic i_clk,
	input wire logic i_resetn,
	output logic [PHASES-1:0] o_phase
	);

	logic [PHASES-1:0] phase_reg;
	logic [PHASES-1:0] phase_next;

	// Rotate the single hot bit; exactly one phase is ever active
	assign phase_next = {phase_reg[PHASES-2:0], phase_reg[PHASES-1]};

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			phase_reg <= PHASES'(PHASE_RESET);
		else
			phase_reg <= phase_next;
	end

	assign o_phase = phase_reg;

endmodule
`default_nettype wire

// ---- core/mcis_file_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcis_file_ram
	import mcis_pkg::*;
	#(
	parameter int DEPTH = FILE_DEPTH,
	parameter int AW = FADDR_W,
	parameter int DW = DATA_W
	)
	(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [DW-1:0] i_wr_data,
	input wire logic i_rd_en,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [DW-1:0] o_rd_data
	);

	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rd_reg;

	// Array has no reset so it maps onto plain RAM cells
	always_ff @(posedge i_clk)
	begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
	end

	// Registered read; data valid one clock after the request
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			rd_reg <= DW'(DATA_ZERO);
		else if (i_rd_en)
			rd_reg <= mem[i_rd_addr];
	end

	assign o_rd_data = rd_reg;

endmodule
`default_nettype wire

// ---- test/mcis_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcis_core_props
	import mcis_pkg::*;
	(
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	input wire logic [PC_W-1:0] I_STACK_TOP,
	input wire logic [PC_W-1:0] O_PC,
	input wire logic [DATA_W-1:0] O_W,
	input wire logic O_STATUS_Z,
	input wire logic [DATA_W-1:0] O_OPTION,
	input wire logic [3:0] O_PHASE,
	input wire logic O_STACK_POP,
	input wire logic O_FILE_WE,
	input wire logic O_SECOND_CYCLE
	);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RESETN);

	// Phase walk, program counter and stack
	property p_phase;
		O_PHASE[0] |-> $onehot(O_PHASE) ##1 O_PHASE[1] ##1 O_PHASE[2]
			##1 O_PHASE[3] ##1 O_PHASE[0];
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase order broken");
	property p_pc_hold;
		!O_PHASE[3] |=> $stable(O_PC);
	endproperty
	a_pc_hold: assert property (p_pc_hold)
		else $error("program counter moved mid cycle");
	property p_pc_step;
		O_PHASE[3] && !O_STACK_POP |=> O_PC == $past(O_PC) + 13'h0001;
	endproperty
	a_pc_step: assert property (p_pc_step)
		else $error("program counter did not step by one");
	property p_pop_pc;
		O_STACK_POP |=> O_PC == $past(I_STACK_TOP);
	endproperty
	a_pop_pc: assert property (p_pop_pc)
		else $error("program counter not loaded from stack top");
	property p_pop_ph;
		O_STACK_POP |-> O_PHASE[3];
	endproperty
	a_pop_ph: assert property (p_pop_ph)
		else $error("pop outside phase four");
	property p_second;
		O_STACK_POP |=> O_SECOND_CYCLE [*4] ##1 !O_SECOND_CYCLE;
	endproperty
	a_second: assert property (p_second)
		else $error("return did not idle one cycle");
	// Idle cycle and write timing
	property p_idle;
		O_SECOND_CYCLE |=> $stable(O_W) && $stable(O_STATUS_Z)
			&& !O_FILE_WE && !O_STACK_POP;
	endproperty
	a_idle: assert property (p_idle)
		else $error("state changed in idle cycle");
	property p_we_ph;
		O_FILE_WE |-> O_PHASE[3];
	endproperty
	a_we_ph: assert property (p_we_ph)
		else $error("file write outside phase four");
	property p_w_hold;
		!O_PHASE[3] |=> $stable(O_W) && $stable(O_STATUS_Z)
			&& $stable(O_OPTION);
	endproperty
	a_w_hold: assert property (p_w_hold)
		else $error("result written before phase four");
	c_pop: cover property (O_STACK_POP);
	c_we: cover property (O_FILE_WE);
	c_idle: cover property (O_SECOND_CYCLE ##4 !O_SECOND_CYCLE);
endmodule
`default_nettype wire

// ---- test/mcis_prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcis_prog_mem
	import mcis_pkg::*;
	(
	input wire logic [PC_W-1:0] i_addr,
	output logic [WORD_W-1:0] o_word
	);
	logic [WORD_W-1:0] mem [0:(1<<PC_W)-1];
	// Unwritten cells read as no-op so a stray fetch is harmless
	initial
	begin
		foreach (mem[a])
			mem[a] = WORD_NOP;
	end
	// No wait state; word follows the address at once
	assign o_word = mem[i_addr];
endmodule
`default_nettype wire

// ---- test/mcu_core_instruction_subset_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu_core_instruction_subset_test
	import mcis_pkg::*;
	;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [PC_W-1:0] top = 13'h0000;
	logic [WORD_W-1:0] instr;
	logic [PC_W-1:0] pc;
	logic [DATA_W-1:0] w, opt, fdata;
	logic [FADDR_W-1:0] faddr;
	logic [3:0] ph;
	logic z, pop, fwe, sec, uns;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	// Clock and design under test
	always #50 clk = ~clk;
	mcis_prog_mem i_mem (.i_addr(pc), .o_word(instr));
	mcis_core i_dut (.I_SYS_CLK(clk), .I_RESETN(resetn), .I_INSTR(instr),
		.I_STACK_TOP(top), .O_PC(pc), .O_W(w), .O_STATUS_Z(z),
		.O_OPTION(opt), .O_PHASE(ph), .O_STACK_POP(pop),
		.O_FILE_WE(fwe), .O_FILE_ADDR(faddr), .O_FILE_DATA(fdata),
		.O_SECOND_CYCLE(sec), .O_UNSUPPORTED(uns));

	task automatic wrap_up();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, far above the hundred or so cycles needed
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 1000)
		begin
			errors++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Place a word at the current address; return once it is taken
	task automatic put(input logic [WORD_W-1:0] word);
		int n;
		i_mem.mem[pc] = word;
		n = 0;
		while (!(ph[3] === 1'b1 && pop === 1'b0) && n < 12)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
	endtask

	// Results of a word are seen once the next word is taken
	task automatic t_literal();
		put(14'h3300);
		chk("uns", 1'b0, uns);
		put(14'h3800);
		chk("w", 8'h00, w);
		chk("z", 1'b0, z);
		put(14'h309A);
		chk("z", 1'b1, z);
		put(14'h3835);
		chk("z", 1'b1, z);
		put(WORD_NOP);
		chk("w", 8'hBF, w);
		chk("z", 1'b0, z);
	endtask

	task automatic t_file();
		put(14'h30FF);
		// direct store, the form software should use
		put(14'h00FF);
		put(14'h0AFF);
		chk("fdata", 8'hFF, fdata);
		chk("z", 1'b0, z);
		put(14'h0A7F);
		chk("fdata", 8'h00, fdata);
		chk("faddr", 7'h7F, faddr);
		chk("z", 1'b1, z);
		chk("w", 8'hFF, w);
		put(14'h08FF);
		chk("w", 8'h01, w);
		chk("z", 1'b0, z);
		put(14'h087F);
		chk("w", 8'h01, w);
		chk("z", 1'b1, z);
		put(WORD_NOP);
		chk("w", 8'h00, w);
	endtask

	task automatic t_option();
		put(14'h304F);
		put(14'h0062);
		put(14'h0060);
		chk("opt", 8'h4F, opt);
		chk("z", 1'b1, z);
		put(14'h0063);
		repeat (2) @(negedge clk);
		chk("uns", 1'b1, uns);
		put(WORD_NOP);
		chk("w", 8'h4F, w);
		chk("opt", 8'h4F, opt);
	endtask

	// Return pair, the second taken from the stack target
	task automatic t_return();
		top = 13'h0040;
		put(14'h3411);
		repeat (4) @(negedge clk);
		chk("pc", 13'h0040, pc);
		chk("w", 8'h11, w);
		chk("sec", 1'b1, sec);
		top = 13'h0100;
		put(WORD_RETURN);
		repeat (4) @(negedge clk);
		chk("pc", 13'h0100, pc);
		chk("w", 8'h11, w);
		put(WORD_NOP);
		chk("pc", 13'h0101, pc);
	endtask

	// Reset held eight cycles, then the scenarios
	initial
	begin
		repeat (8) @(negedge clk);
		chk("opt", 8'hFF, opt);
		resetn = 1'b1;
		t_literal();
		t_file();
		t_option();
		t_return();
		wrap_up();
	end
endmodule

bind mcis_core mcis_core_props i_props (.I_SYS_CLK, .I_RESETN,
	.I_STACK_TOP, .O_PC, .O_W, .O_STATUS_Z, .O_OPTION, .O_PHASE,
	.O_STACK_POP, .O_FILE_WE, .O_SECOND_CYCLE);
`default_nettype wire
